// *** ssto_core.v ***
`timescale 1ns/1ps
`include "ssto_map.vh"
module ssto_core (
	input wire ref_clk, // 50 MHz clock
	input wire rstn, // Async reset, active low
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [11:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output reg pready, // APB ready
	output reg pslverr, // APB error
	output reg [7:0] dirPort5, // Port 5 direction register
	output reg [7:0] dirPort6, // Port 6 direction register
	output reg [7:0] dirPort7, // Port 7 direction register
	output reg execDone // Pulse at end of Q4
);
	localparam PH_IDLE = `SSTO_PH_IDLE;
	localparam PH_Q1 = `SSTO_PH_Q1;
	localparam PH_Q2 = `SSTO_PH_Q2;
	localparam PH_Q3 = `SSTO_PH_Q3;
	localparam PH_Q4 = `SSTO_PH_Q4;

	// File registers, written by the bus or by Q4
	reg [7:0] fileMem [0:`SSTO_FILE_WORDS-1];
	reg [13:0] instr_r;
	reg [7:0] acc_r;
	reg carry_r;
	reg digit_carry_flag_r;
	reg zero_r;
	reg [2:0] phase_r;
	reg [2:0] phase_nxt;
	reg [7:0] fileVal_r;
	reg [7:0] result_r;
	reg resC_r;
	reg resDc_r;
	// Decoded operation, captured in Q1 and held through Q4
	reg isSub_r;
	reg isSwap_r;
	reg isDir_r;
	reg destFile_r;

	// Bus phase decodes
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire busy = (phase_r != PH_IDLE);
	wire isFileAddr = (paddr >= `SSTO_ADDR_FILE) &&
		(paddr < `SSTO_ADDR_FILE + 4 * `SSTO_FILE_WORDS);
	wire [6:0] fileIdx = paddr[`SSTO_F_IDX_HI:`SSTO_F_IDX_LO];
	// Instruction fields, named once so decode and execute agree
	wire [5:0] opField = instr_r[`SSTO_F_OP_HI:`SSTO_F_OP_LO];
	wire [10:0] dirField = instr_r[`SSTO_F_OP_HI:`SSTO_F_DIR_LO];
	wire [2:0] selField = instr_r[`SSTO_F_SEL_HI:`SSTO_F_LSB];
	wire destBit = instr_r[`SSTO_F_DEST];
	wire [6:0] opFile = instr_r[`SSTO_F_FILE_HI:`SSTO_F_LSB];
	// Nine-bit difference keeps the borrow in its top bit
	wire [8:0] diff = {1'b0, fileVal_r} - {1'b0, acc_r};
	// Low-nibble difference; its top bit is the nibble borrow
	wire [4:0] diffLo = {1'b0, fileVal_r[3:0]} - {1'b0, acc_r[3:0]};

	// Known register address check, used by the error logic
	function known;
		input [11:0] a;
		begin
			known = (a == `SSTO_ADDR_INSTR) || (a == `SSTO_ADDR_ACC) ||
				(a == `SSTO_ADDR_STATUS) || (a == `SSTO_ADDR_DIR5) ||
				(a == `SSTO_ADDR_DIR6) || (a == `SSTO_ADDR_DIR7);
		end
	endfunction

	// Bus write hitting one register address
	function wrHit;
		input [11:0] a;
		begin
			wrHit = access && pwrite && (paddr == a);
		end
	endfunction

	// Phase sequencer; writing INSTR launches Q1
	always @* begin
		phase_nxt = phase_r;
		case (phase_r)
			PH_IDLE: begin
				if (wrHit(`SSTO_ADDR_INSTR)) begin
					phase_nxt = PH_Q1;
				end
			end
			PH_Q1: phase_nxt = PH_Q2;
			PH_Q2: phase_nxt = PH_Q3;
			PH_Q3: phase_nxt = PH_Q4;
			PH_Q4: phase_nxt = PH_IDLE;
			default: phase_nxt = PH_IDLE;
		endcase
	end

	// APB answers in the access cycle; no wait states
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			// Unmapped addresses still complete, but flag an error
			pready <= setup;
			pslverr <= setup && !(known(paddr) || isFileAddr);
			prdata <= 32'h00000000;
			if (setup && !pwrite) begin
				if (isFileAddr) begin
					prdata <= {24'h000000, fileMem[fileIdx]};
				end else if (paddr == `SSTO_ADDR_INSTR) begin
					prdata <= {18'h00000, instr_r};
				end else if (paddr == `SSTO_ADDR_ACC) begin
					prdata <= {24'h000000, acc_r};
				end else if (paddr == `SSTO_ADDR_STATUS) begin
					prdata <= {28'h0000000, busy, zero_r, digit_carry_flag_r, carry_r};
				end else if (paddr == `SSTO_ADDR_DIR5) begin
					prdata <= {24'h000000, dirPort5};
				end else if (paddr == `SSTO_ADDR_DIR6) begin
					prdata <= {24'h000000, dirPort6};
				end else if (paddr == `SSTO_ADDR_DIR7) begin
					prdata <= {24'h000000, dirPort7};
				end
			end
		end
	end

	// Pipeline and architectural state; execute wins over bus writes
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			phase_r <= PH_IDLE;
			instr_r <= 14'h0000;
			acc_r <= 8'h00;
			carry_r <= 1'b0;
			digit_carry_flag_r <= 1'b0;
			zero_r <= 1'b0;
			fileVal_r <= 8'h00;
			result_r <= 8'h00;
			resC_r <= 1'b0;
			resDc_r <= 1'b0;
			isSub_r <= 1'b0;
			isSwap_r <= 1'b0;
			isDir_r <= 1'b0;
			destFile_r <= 1'b0;
			dirPort5 <= `SSTO_RST_DIR;
			dirPort6 <= `SSTO_RST_DIR;
			dirPort7 <= `SSTO_RST_DIR;
			execDone <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			execDone <= (phase_r == PH_Q4);
			// Bus writes accepted only when idle, so a running op sees stable inputs
			if (access && pwrite && !busy) begin
				if (paddr == `SSTO_ADDR_INSTR) instr_r <= pwdata[13:0];
				if (paddr == `SSTO_ADDR_ACC) acc_r <= pwdata[7:0];
				if (paddr == `SSTO_ADDR_STATUS) begin
					carry_r <= pwdata[`SSTO_ST_C];
					digit_carry_flag_r <= pwdata[`SSTO_ST_DC];
					zero_r <= pwdata[`SSTO_ST_Z];
				end
			end
			case (phase_r)
				PH_Q1: begin
					// Decode
					isSub_r <= (opField == `SSTO_OP_SUB);
					isSwap_r <= (opField == `SSTO_OP_SWAP);
					// Operand 5 to 7 only; other values never set isDir_r
					isDir_r <= (dirField == `SSTO_OP_DIR) &&
						(selField >= `SSTO_DIR_LO) &&
						(selField <= `SSTO_DIR_HI);
					destFile_r <= destBit;
				end
				PH_Q2: fileVal_r <= fileMem[opFile];
				PH_Q3: begin
					if (isSub_r) begin
						result_r <= diff[7:0];
						resC_r <= !diff[8];
						resDc_r <= !diffLo[4];
					end else begin
						// Also runs for other opcodes; Q4 never writes it then
						result_r <= {fileVal_r[3:0], fileVal_r[7:4]};
					end
				end
				PH_Q4: begin
					// Write back; flags move only for subtract
					if ((isSub_r || isSwap_r) && !destFile_r) begin
						acc_r <= result_r;
					end
					if (isSub_r) begin
						carry_r <= resC_r;
						digit_carry_flag_r <= resDc_r;
						zero_r <= (result_r == 8'h00);
					end
					if (isDir_r) begin
						case (selField)
							`SSTO_DIR_LO: dirPort5 <= acc_r;
							`SSTO_DIR_HI: dirPort7 <= acc_r;
							default: dirPort6 <= acc_r;
						endcase
					end
				end
				default: begin
				end
			endcase
		end
	end

	// File memory has no reset; one write port shared by bus and Q4
	always @(posedge ref_clk) begin
		if (phase_r == PH_Q4 && (isSub_r || isSwap_r) && destFile_r) begin
			fileMem[opFile] <= result_r;
		end else if (access && pwrite && !busy && isFileAddr) begin
			fileMem[fileIdx] <= pwdata[7:0];
		end
	end
endmodule // ssto_core

// *** ssto_map.vh ***
`ifndef SSTO_MAP_VH
`define SSTO_MAP_VH
// APB register byte addresses
`define SSTO_ADDR_INSTR 12'h000
`define SSTO_ADDR_ACC 12'h004
`define SSTO_ADDR_STATUS 12'h008
`define SSTO_ADDR_DIR5 12'h00C
`define SSTO_ADDR_DIR6 12'h010
`define SSTO_ADDR_DIR7 12'h014
`define SSTO_ADDR_FILE 12'h400
// File window: 128 words from FILE base
`define SSTO_FILE_WORDS 128
// Opcode fields
`define SSTO_OP_SUB 6'h02
`define SSTO_OP_SWAP 6'h0E
`define SSTO_OP_DIR 11'h00C
`define SSTO_DIR_LO 3'h5
`define SSTO_DIR_HI 3'h7
// Status bit positions
`define SSTO_ST_C 0
`define SSTO_ST_DC 1
`define SSTO_ST_Z 2
`define SSTO_ST_BUSY 3
// Phase codes
`define SSTO_PH_IDLE 3'h0
`define SSTO_PH_Q1 3'h1
`define SSTO_PH_Q2 3'h2
`define SSTO_PH_Q3 3'h3
`define SSTO_PH_Q4 3'h4
// Instruction field positions
`define SSTO_F_OP_HI 13
`define SSTO_F_OP_LO 8
`define SSTO_F_DEST 7
`define SSTO_F_FILE_HI 6
`define SSTO_F_DIR_LO 3
`define SSTO_F_SEL_HI 2
`define SSTO_F_LSB 0
// Word index field of a file address
`define SSTO_F_IDX_HI 8
`define SSTO_F_IDX_LO 2
// Reset values
`define SSTO_RST_DIR 8'hFF
`endif

// *** ssto_core_asserts.sv ***
`timescale 1ns/1ps
`include "ssto_map.vh"
module ssto_core_asserts (
	input wire ref_clk, // Clock
	input wire rstn, // Reset
	input wire psel, // Select
	input wire penable, // Enable
	input wire pwrite, // Direction
	input wire [11:0] paddr, // Address
	input wire [31:0] pwdata, // Wdata
	input wire [31:0] prdata, // Rdata
	input wire pready, // Ready
	input wire pslverr, // Error
	input wire [7:0] dirPort5, // Dir 5
	input wire [7:0] dirPort6, // Dir 6
	input wire [7:0] dirPort7, // Dir 7
	input wire execDone // Done
);
	// One domain, so one clock and reset serve all
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// Setup cycle, and setup of a launching write
	sequence s_setup; psel && !penable; endsequence
	sequence s_go; s_setup ##0 (pwrite && paddr == `SSTO_ADDR_INSTR); endsequence
	property p_rdy; s_setup |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("long ready");
	property p_zero; !pready |-> prdata == 32'h0; endproperty
	a_zero: assert property (p_zero) else $error("stray rdata");
	property p_hi; pready && !pslverr |-> prdata[31:14] == 18'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper bits");
	property p_map; s_setup ##0 (paddr > `SSTO_ADDR_DIR7 && paddr < `SSTO_ADDR_FILE) |=> pslverr;
	endproperty
	a_map: assert property (p_map) else $error("no error");
	// Access cycle and four phases, then the pulse
	property p_exec; s_go |=> !execDone [*5] ##1 execDone; endproperty
	a_exec: assert property (p_exec) else $error("bad timing");
	property p_pulse; execDone |=> !execDone; endproperty
	a_pulse: assert property (p_pulse) else $error("long done");
	property p_dir; !$stable({dirPort5, dirPort6, dirPort7}) |-> execDone; endproperty
	a_dir: assert property (p_dir) else $error("dir moved");
endmodule // ssto_core_asserts
bind ssto_core ssto_core_asserts u_chk (
	.ref_clk(ref_clk),
	.rstn(rstn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.dirPort5(dirPort5),
	.dirPort6(dirPort6),
	.dirPort7(dirPort7),
	.execDone(execDone)
);

// *** test_ssto_core.sv ***
`timescale 1ns/1ps
`include "ssto_map.vh"
module test_ssto_core;
	reg ref_clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, er;
	reg [11:0] paddr = 12'h0;
	reg [31:0] pwdata = 32'h0, rd;
	wire [31:0] prdata;
	wire pready, pslverr, execDone;
	wire [7:0] dirPort5, dirPort6, dirPort7;
	integer error_cnt = 0, n_tests = 0, i;
	ssto_core u_ssto_core (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.dirPort5(dirPort5),
		.dirPort6(dirPort6),
		.dirPort7(dirPort7),
		.execDone(execDone)
	);
	// 50 MHz clock
	always #10 ref_clk = ~ref_clk;
	task report_and_stop; begin
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	end endtask
	task check(input [31:0] seen, input [31:0] exp); begin
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("MISMATCH %0t seen %h want %h", $time, seen, exp);
		end
	end endtask
	// A hang counts as a mismatch
	task hang; begin
		check(32'h0, 32'h1);
		report_and_stop;
	end endtask
	// Request held until pready is sampled high
	task apb(input w, input [11:0] a, input [31:0] d); begin
		@(posedge ref_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		for (i = 0; i < 9 && pready !== 1'h1; i = i + 1) @(posedge ref_clk);
		if (i == 9) hang;
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	end endtask
	// Results only read after done, since busy writes are dropped
	task run(input [6:0] f, input [7:0] fv, input [7:0] av, input [13:0] ins); begin
		apb(1'h1, `SSTO_ADDR_FILE + {f, 2'h0}, {24'h0, fv});
		apb(1'h1, `SSTO_ADDR_ACC, {24'h0, av});
		apb(1'h1, `SSTO_ADDR_INSTR, {18'h0, ins});
		for (i = 0; i < 9 && execDone !== 1'h1; i = i + 1) @(posedge ref_clk);
		if (i == 9) hang;
	end endtask
	task res(input [6:0] f, input [7:0] fe, input [7:0] ae, input [2:0] se); begin
		apb(1'h0, `SSTO_ADDR_FILE + {f, 2'h0}, 32'h0);
		check(rd, {24'h0, fe});
		apb(1'h0, `SSTO_ADDR_ACC, 32'h0);
		check(rd, {24'h0, ae});
		apb(1'h0, `SSTO_ADDR_STATUS, 32'h0);
		check(rd, {29'h0, se});
	end endtask
	// Ports 5 to 7 loaded, operand 4 must do nothing
	task t_dir; begin
		check({8'h0, dirPort5, dirPort6, dirPort7}, 32'h00FFFFFF);
		run(7'h00, 8'h00, 8'h12, 14'h0065);
		run(7'h00, 8'h00, 8'h78, 14'h0066);
		run(7'h00, 8'h00, 8'h34, 14'h0067);
		run(7'h00, 8'h00, 8'h56, 14'h0064);
		check({8'h0, dirPort5, dirPort6, dirPort7}, 32'h00127834);
		res(7'h00, 8'h00, 8'h56, 3'h0);
	end endtask
	task t_sub; begin
		run(7'h03, 8'h03, 8'h02, {6'h02, 1'h1, 7'h03});
		res(7'h03, 8'h01, 8'h02, 3'h3);
		run(7'h7F, 8'h02, 8'h02, {6'h02, 1'h0, 7'h7F});
		res(7'h7F, 8'h02, 8'h00, 3'h7);
		run(7'h00, 8'h01, 8'h02, {6'h02, 1'h1, 7'h00});
		res(7'h00, 8'hFF, 8'h02, 3'h0);
		run(7'h05, 8'h10, 8'h01, {6'h02, 1'h1, 7'h05});
		res(7'h05, 8'h0F, 8'h01, 3'h1);
	end endtask
	// Flags left from the last subtract must survive
	task t_swap; begin
		run(7'h09, 8'hA5, 8'h00, {6'h0E, 1'h0, 7'h09});
		res(7'h09, 8'hA5, 8'h5A, 3'h1);
		run(7'h40, 8'h3C, 8'h11, {6'h0E, 1'h1, 7'h40});
		res(7'h40, 8'hC3, 8'h11, 3'h1);
	end endtask
	task t_map; begin
		apb(1'h0, 12'h018, 32'h0);
		check({31'h0, er}, 32'h1);
		check(rd, 32'h0);
	end endtask
	// Reset while idle, after an ACC write, restores direction, ACC and flag defaults, file kept
	task t_rst; begin
		apb(1'h1, `SSTO_ADDR_ACC, 32'h0000009A);
		@(posedge ref_clk);
		rstn <= 1'h0;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'h1;
		check({8'h0, dirPort5, dirPort6, dirPort7}, 32'h00FFFFFF);
		res(7'h40, 8'hC3, 8'h00, 3'h0);
	end endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		rstn <= 1'h1;
		t_dir;
		t_sub;
		t_swap;
		t_map;
		t_rst;
		report_and_stop;
	end
endmodule // test_ssto_core
